// File: hw/icf_fifo_ctrl.sv
// fifo level, receive length, transmit threshold and flush control
//
// Overview of operation
// [R1] receive fifo byte count readable in 11:8
// [R2] master receives programmed byte count, zero means 256
// [R3] threshold flag sets when tx level <= threshold
// [R4] software keeps threshold between one and seven
// [R5] writing flush bit empties the transmit fifo
// [R6] flush bit clears itself when flush done
// [R7] software preserves reserved bits on writes
// [R8] both fifos hold eight bytes
// [R9] after flush tx level reads zero, threshold rechecked
`timescale 1ns/1ps
`include "icf_params.svh"
module icf_fifo_ctrl
  import icf_pkg::*;
#(
  parameter int DEPTH = `ICF_FIFO_DEPTH
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire icf_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  // shifter side, on the link clock
  input wire logic clk_link,
  output logic [7:0] link_tx_data,
  output logic link_tx_valid,
  input wire logic link_tx_ready,
  input wire icf_byte_t link_rx,
  output logic link_rx_ready,
  // protocol engine side
  input wire logic xact_start,
  output logic [8:0] rx_xact_len,
  output logic rx_xact_done,
  output logic tx_threshold_flag
);

  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH + 1);
  localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  logic [7:0] tx_mem [DEPTH];
  logic [7:0] rx_mem [DEPTH];
  logic [PW-1:0] tx_wp_r;
  logic [PW-1:0] tx_rp_r;
  logic [LW-1:0] tx_lvl_r;
  logic [PW-1:0] rx_wp_r;
  logic [PW-1:0] rx_rp_r;
  logic [LW-1:0] rx_lvl_r;
  logic [7:0] rxcnt_r;
  logic [3:0] txth_r;
  logic flush_r;
  logic flag_r;
  logic [8:0] rx_left_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_rx_ctrl;
  logic wr_tx_ctrl;
  logic wr_status;
  logic wr_data;
  logic rd_data;
  logic flush_req;
  logic tx_push;
  logic tx_pop;
  logic tx_s_valid;
  logic tx_s_ready;
  logic rx_push;
  logic rx_pop;
  logic rx_d_valid;
  logic rx_d_ready;
  logic [7:0] rx_d_data;

  assign wr_rx_ctrl = bus_req.wr_stb && reg_hit(bus_req.addr, `ICF_OFS_RX_CTRL);
  assign wr_tx_ctrl = bus_req.wr_stb && reg_hit(bus_req.addr, `ICF_OFS_TX_CTRL);
  assign wr_status = bus_req.wr_stb && reg_hit(bus_req.addr, `ICF_OFS_STATUS);
  assign wr_data = bus_req.wr_stb && reg_hit(bus_req.addr, `ICF_OFS_DATA);
  assign rd_data = bus_req.rd_stb && reg_hit(bus_req.addr, `ICF_OFS_DATA);
  assign flush_req = wr_tx_ctrl && bus_req.wdata[`ICF_TXFSH_BIT];

  // software side of the transmit fifo; full drops the write
  assign tx_push = wr_data && (tx_lvl_r != FULL_LVL) && !flush_r;
  // nothing leaves while a flush is pending
  assign tx_s_valid = (tx_lvl_r != '0) && !flush_r;
  assign tx_pop = tx_s_valid && tx_s_ready;

  // bytes beyond the transaction length are held back
  assign rx_d_ready = (rx_lvl_r != FULL_LVL) && (rx_left_r != '0); // [R2]
  assign rx_push = rx_d_valid && rx_d_ready;
  assign rx_pop = rd_data && (rx_lvl_r != '0);

  assign rx_xact_len = (rxcnt_r == 8'h00) ? `ICF_RX_LEN_MAX : {1'b0, rxcnt_r}; // [R2]
  assign rx_xact_done = (rx_left_r == '0);
  assign tx_threshold_flag = flag_r;
  assign bus_rdata = rdata_r;

  // transmit bytes toward the link clock
  icf_xfer_sync #(
    .WIDTH(8)
  ) u_tx_sync (
    .clk_src(clk_sys),
    .rst_b(rst_b),
    .src_valid(tx_s_valid),
    .src_data(tx_mem[tx_rp_r]),
    .src_ready(tx_s_ready),
    .clk_dst(clk_link),
    .dst_valid(link_tx_valid),
    .dst_data(link_tx_data),
    .dst_ready(link_tx_ready)
  );

  // received bytes back to the system clock
  icf_xfer_sync #(
    .WIDTH(8)
  ) u_rx_sync (
    .clk_src(clk_link),
    .rst_b(rst_b),
    .src_valid(link_rx.valid),
    .src_data(link_rx.data),
    .src_ready(link_rx_ready),
    .clk_dst(clk_sys),
    .dst_valid(rx_d_valid),
    .dst_data(rx_d_data),
    .dst_ready(rx_d_ready)
  );

  // control fields
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rxcnt_r <= `ICF_RXCNT_RST;
    end else if (wr_rx_ctrl) begin
      rxcnt_r <= bus_req.wdata[`ICF_RXCNT_MSB:`ICF_RXCNT_LSB]; // [R2]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      txth_r <= `ICF_TXTH_RST;
    end else if (wr_tx_ctrl) begin
      txth_r <= bus_req.wdata[`ICF_TXTH_MSB:`ICF_TXTH_LSB];
    end
  end

  // flush request lives one cycle after the last flush write, then clears itself
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flush_r <= `ICF_FLUSH_RST;
    end else if (flush_req) begin
      flush_r <= 1'b1; // [R5]
    end else if (flush_r) begin
      flush_r <= 1'b0; // [R6]
    end
  end

  // transmit fifo storage
  always_ff @(posedge clk_sys) begin
    if (tx_push) begin
      tx_mem[tx_wp_r] <= bus_req.wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_lvl_r <= '0;
    end else if (flush_r) begin
      tx_wp_r <= '0; // [R5]
      tx_rp_r <= '0;
      tx_lvl_r <= '0; // [R9]
    end else begin
      if (tx_push) begin
        tx_wp_r <= PW'(tx_wp_r + 1'b1); // [R8]
      end
      if (tx_pop) begin
        tx_rp_r <= PW'(tx_rp_r + 1'b1);
      end
      if (tx_push && !tx_pop) begin
        tx_lvl_r <= LW'(tx_lvl_r + 1'b1);
      end else if (tx_pop && !tx_push) begin
        tx_lvl_r <= LW'(tx_lvl_r - 1'b1);
      end
    end
  end

  // sticky threshold flag; a set in the clear cycle wins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
    end else if (tx_lvl_r <= LW'(txth_r)) begin
      flag_r <= 1'b1; // [R3] [R9]
    end else if (wr_status && bus_req.wdata[`ICF_STS_FLAG_BIT]) begin
      flag_r <= 1'b0;
    end
  end

  // receive fifo storage
  always_ff @(posedge clk_sys) begin
    if (rx_push) begin
      rx_mem[rx_wp_r] <= rx_d_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_lvl_r <= '0;
    end else begin
      if (rx_push) begin
        rx_wp_r <= PW'(rx_wp_r + 1'b1); // [R8]
      end
      if (rx_pop) begin
        rx_rp_r <= PW'(rx_rp_r + 1'b1);
      end
      if (rx_push && !rx_pop) begin
        rx_lvl_r <= LW'(rx_lvl_r + 1'b1); // [R1]
      end else if (rx_pop && !rx_push) begin
        rx_lvl_r <= LW'(rx_lvl_r - 1'b1);
      end
    end
  end

  // bytes still to receive in the current master transaction
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_left_r <= '0;
    end else if (xact_start) begin
      rx_left_r <= rx_xact_len; // [R2]
    end else if (rx_push) begin
      rx_left_r <= rx_left_r - 9'h001;
    end
  end

  // read mux; reserved bits read zero
  always_comb begin
    rdata_nxt = '0;
    if (!bus_req.rd_stb) begin
      rdata_nxt = '0;
    end else if (reg_hit(bus_req.addr, `ICF_OFS_RX_CTRL)) begin
      rdata_nxt[`ICF_RXLVL_MSB:`ICF_RXLVL_LSB] = rx_lvl_r; // [R1]
      rdata_nxt[`ICF_RXCNT_MSB:`ICF_RXCNT_LSB] = rxcnt_r;
    end else if (reg_hit(bus_req.addr, `ICF_OFS_TX_CTRL)) begin
      rdata_nxt[`ICF_TXTH_MSB:`ICF_TXTH_LSB] = txth_r;
      rdata_nxt[`ICF_TXFSH_BIT] = flush_r; // [R6]
    end else if (reg_hit(bus_req.addr, `ICF_OFS_STATUS)) begin
      rdata_nxt[`ICF_STS_TXLVL_MSB:`ICF_STS_TXLVL_LSB] = tx_lvl_r;
      rdata_nxt[`ICF_STS_DONE_BIT] = rx_xact_done;
      rdata_nxt[`ICF_STS_FLAG_BIT] = flag_r;
    end else if (reg_hit(bus_req.addr, `ICF_OFS_DATA)) begin
      if (rx_lvl_r != '0) begin
        rdata_nxt[7:0] = rx_mem[rx_rp_r];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= `ICF_RDATA_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // checks on the system clock
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence flush_write_s;
    flush_req && !flush_r;
  endsequence

  // a second flush write right behind the first keeps the bit up one more cycle
  sequence flush_done_s;
    flush_r ##1 (!flush_r || $past(flush_req)) && (tx_lvl_r == '0);
  endsequence

  rx_level_bound_a: assert property ( // [R1]
    rx_lvl_r <= FULL_LVL && !(rx_lvl_r == FULL_LVL && rx_push))
    else $error("receive level past depth");

  rx_level_pop_a: assert property ( // [R1]
    rx_pop && !rx_push |=> rx_lvl_r == $past(rx_lvl_r) - LW'(1))
    else $error("receive level not lowered by a read");

  rx_len_load_a: assert property ( // [R2]
    xact_start |=> rx_left_r == (($past(rxcnt_r) == 8'h00) ? 9'h100 : {1'b0, $past(rxcnt_r)}))
    else $error("transaction length loaded wrong");

  rx_len_stop_a: assert property ( // [R2]
    rx_left_r == '0 && !xact_start |=> rx_left_r == '0 && !rx_push)
    else $error("byte taken beyond transaction length");

  tx_thresh_set_a: assert property ( // [R3]
    tx_lvl_r <= LW'(txth_r) |=> tx_threshold_flag)
    else $error("threshold flag not set");

  tx_flush_run_a: assert property ( // [R5]
    flush_write_s |=> flush_done_s)
    else $error("flush did not empty the transmit fifo");

  flush_self_clear_a: assert property ( // [R6]
    flush_r && !flush_req |=> !flush_r)
    else $error("flush bit did not clear itself");

  flush_empty_flag_a: assert property ( // [R9]
    flush_r ##1 !flush_r |=> tx_threshold_flag)
    else $error("threshold not rechecked after flush");

  tx_level_bound_a: assert property ( // [R8]
    tx_lvl_r <= FULL_LVL && !(tx_lvl_r == FULL_LVL && tx_push))
    else $error("transmit level past depth");

  // push, count, clear, flush hold and idle read checks
  rx_level_push_a: assert property ( // [R1]
    rx_push && !rx_pop |=> rx_lvl_r == $past(rx_lvl_r) + LW'(1))
    else $error("receive level not raised by a push");

  rx_len_count_a: assert property ( // [R2]
    rx_push && !xact_start |=> rx_left_r == $past(rx_left_r) - 9'h001)
    else $error("remaining count not lowered by a byte");

  flag_clear_a: assert property ( // [R3]
    wr_status && bus_req.wdata[`ICF_STS_FLAG_BIT] && !(tx_lvl_r <= LW'(txth_r)) |=> !tx_threshold_flag)
    else $error("threshold flag not cleared");

  flush_hold_tx_a: assert property ( // [R5]
    flush_r |-> !tx_push && !tx_s_valid)
    else $error("transmit fifo moved during flush");

  rdata_idle_a: assert property (
    !bus_req.rd_stb |=> bus_rdata == '0)
    else $error("read data outside the answer cycle");

endmodule // icf_fifo_ctrl

// File: hw/icf_params.svh
// offsets, field positions, reset values and sizes of the fifo control block
`ifndef ICF_PARAMS_SVH
`define ICF_PARAMS_SVH

// register offsets
`define ICF_OFS_RX_CTRL 8'h20
`define ICF_OFS_TX_CTRL 8'h24
`define ICF_OFS_STATUS 8'h30
`define ICF_OFS_DATA 8'h34

// receive_control_one fields
`define ICF_RXCNT_LSB 0
`define ICF_RXCNT_MSB 7
`define ICF_RXLVL_LSB 8
`define ICF_RXLVL_MSB 11

// transmit_control_zero fields
`define ICF_TXFSH_BIT 7
`define ICF_TXTH_LSB 8
`define ICF_TXTH_MSB 11

// status fields
`define ICF_STS_FLAG_BIT 0
`define ICF_STS_DONE_BIT 1
`define ICF_STS_TXLVL_LSB 8
`define ICF_STS_TXLVL_MSB 11

// reset values
`define ICF_RXCNT_RST 8'h01
`define ICF_TXTH_RST 4'h0
`define ICF_FLUSH_RST 1'b0
`define ICF_RDATA_RST 32'h0000_0000

// sizes
`define ICF_FIFO_DEPTH 8
`define ICF_RX_LEN_MAX 9'h100

`endif

// File: hw/icf_pkg.sv
// types shared by the fifo control block
package icf_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr_stb;
    logic rd_stb;
  } icf_bus_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } icf_byte_t;

endpackage

// File: hw/icf_xfer_sync.sv
// toggle handshake that carries one word at a time between two clocks
`timescale 1ns/1ps
module icf_xfer_sync #(
  parameter int WIDTH = 8
) (
  // source side
  input wire logic clk_src,
  input wire logic rst_b,
  input wire logic src_valid,
  input wire logic [WIDTH-1:0] src_data,
  output logic src_ready,
  // destination side
  input wire logic clk_dst,
  output logic dst_valid,
  output logic [WIDTH-1:0] dst_data,
  input wire logic dst_ready
);

  logic req_r;
  logic [WIDTH-1:0] data_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic req_s1_r;
  logic req_s2_r;
  logic ack_r;

  assign src_ready = (req_r == ack_s2_r);
  assign dst_valid = (req_s2_r != ack_r);
  // held stable by the source until the ack returns
  assign dst_data = data_r;

  always_ff @(posedge clk_src or negedge rst_b) begin
    if (!rst_b) begin
      req_r <= 1'b0;
      data_r <= '0;
    end else if (src_valid && src_ready) begin
      req_r <= ~req_r;
      data_r <= src_data;
    end
  end

  always_ff @(posedge clk_src or negedge rst_b) begin
    if (!rst_b) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  always_ff @(posedge clk_dst or negedge rst_b) begin
    if (!rst_b) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
    end else begin
      req_s1_r <= req_r;
      req_s2_r <= req_s1_r;
    end
  end

  always_ff @(posedge clk_dst or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else if (dst_valid && dst_ready) begin
      ack_r <= ~ack_r;
    end
  end

endmodule // icf_xfer_sync

// File: test/icf_fifo_ctrl_tb_top.sv
// testbench for the fifo control block
`timescale 1ns/1ps
`define TB_CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin miscompares++; \
  $display("[ERR] %0t got %h want %h", $time, act, exp); end end
module icf_fifo_ctrl_tb_top
  import icf_pkg::*;
;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst_b = 1'b0;
  icf_bus_req_t bus_req = '0;
  logic [31:0] bus_rdata;
  logic [7:0] link_tx_data;
  logic link_tx_valid;
  logic link_tx_ready;
  icf_byte_t link_rx;
  logic link_rx_ready;
  logic xact_start = 1'b0;
  logic [8:0] rx_xact_len;
  logic rx_xact_done;
  logic tx_threshold_flag;
  logic stall = 1'b1;
  logic rx_en = 1'b0;
  logic [7:0] n_taken;
  logic [7:0] last_tx;
  logic [7:0] prev_tx;
  logic [31:0] rd;
  logic [7:0] base;
  int miscompares = 0;
  int samples_checked = 0;

  icf_fifo_ctrl #(.DEPTH(8)) icf_fifo_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .clk_link(clk_link), .link_tx_data(link_tx_data), .link_tx_valid(link_tx_valid),
    .link_tx_ready(link_tx_ready), .link_rx(link_rx), .link_rx_ready(link_rx_ready), .xact_start(xact_start),
    .rx_xact_len(rx_xact_len), .rx_xact_done(rx_xact_done), .tx_threshold_flag(tx_threshold_flag));
  icf_shifter_model icf_shifter_model_i (.clk_link(clk_link), .rst_b(rst_b), .link_tx_data(link_tx_data),
    .link_tx_valid(link_tx_valid), .link_tx_ready(link_tx_ready), .link_rx(link_rx),
    .link_rx_ready(link_rx_ready), .stall(stall), .rx_en(rx_en), .n_taken(n_taken), .last_tx(last_tx),
    .prev_tx(prev_tx));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #3;
    forever #6 clk_link = ~clk_link;
  end

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr_stb: 1'b1, rd_stb: 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
    // let the written field settle before anyone looks at it
    @(negedge clk_sys);
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 32'h0000_0000, wr_stb: 1'b0, rd_stb: 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    @(negedge clk_sys);
    d = bus_rdata;
  endtask

  task automatic complete_run();
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    bus_read(8'h20, rd);
    `TB_CHK(rd, 32'h0000_0001)
    bus_read(8'h24, rd);
    `TB_CHK(rd, 32'h0000_0000)
    bus_read(8'h30, rd);
    `TB_CHK(rd, 32'h0000_0003)
    bus_read(8'h40, rd);
    `TB_CHK(rd, 32'h0000_0000)
    bus_write(8'h20, 32'h0000_0000);
    `TB_CHK(rx_xact_len, 9'h100)
    // fill tx while the shifter stalls; one byte waits at the link
    bus_write(8'h24, 32'h0000_0700);
    for (int i = 0; i < 10; i++) begin
      bus_write(8'h34, 32'h0000_0010 + i);
    end
    bus_read(8'h30, rd);
    `TB_CHK(rd[11:8], 4'h8)
    bus_write(8'h30, 32'h0000_0001);
    bus_read(8'h30, rd);
    `TB_CHK(rd, 32'h0000_0802)
    `TB_CHK(tx_threshold_flag, 1'b0)
    bus_write(8'h24, 32'h0000_0780);
    repeat (2) @(posedge clk_sys);
    bus_read(8'h24, rd);
    `TB_CHK(rd, 32'h0000_0700)
    bus_read(8'h30, rd);
    `TB_CHK(rd, 32'h0000_0003)
    stall <= 1'b0;
    repeat (50) @(posedge clk_sys);
    // only the byte already at the link survives the flush
    `TB_CHK(n_taken, 8'h01)
    `TB_CHK(last_tx, 8'h10)
    base = n_taken;
    bus_write(8'h34, 32'h0000_005a);
    bus_write(8'h34, 32'h0000_005b);
    for (int i = 0; i < 200 && n_taken !== base + 8'h02; i++) begin
      @(posedge clk_sys);
    end
    `TB_CHK(n_taken, base + 8'h02)
    `TB_CHK({prev_tx, last_tx}, 16'h5a5b)
    // receive transaction of three bytes
    bus_write(8'h20, 32'h0000_0003);
    `TB_CHK(rx_xact_len, 9'h003)
    @(posedge clk_sys);
    xact_start <= 1'b1;
    @(posedge clk_sys);
    xact_start <= 1'b0;
    rx_en <= 1'b1;
    // the loaded count is visible only once this edge has settled
    @(negedge clk_sys);
    for (int i = 0; i < 300 && rx_xact_done !== 1'b1; i++) begin
      @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
    bus_read(8'h20, rd);
    `TB_CHK(rd, 32'h0000_0303)
    for (int i = 0; i < 3; i++) begin
      bus_read(8'h34, rd);
      `TB_CHK(rd, 32'h0000_00a0 + i)
    end
    // ten bytes requested, fifo stops at eight
    bus_write(8'h20, 32'h0000_000a);
    @(posedge clk_sys);
    xact_start <= 1'b1;
    @(posedge clk_sys);
    xact_start <= 1'b0;
    repeat (100) @(posedge clk_sys);
    bus_read(8'h20, rd);
    `TB_CHK(rd, 32'h0000_080a)
    `TB_CHK(rx_xact_done, 1'b0)
    for (int i = 0; i < 8; i++) begin
      bus_read(8'h34, rd);
      `TB_CHK(rd, 32'h0000_00a3 + i)
    end
    for (int i = 0; i < 300 && rx_xact_done !== 1'b1; i++) begin
      @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
    bus_read(8'h20, rd);
    `TB_CHK(rd, 32'h0000_020a)
    for (int i = 0; i < 2; i++) begin
      bus_read(8'h34, rd);
      `TB_CHK(rd, 32'h0000_00ab + i)
    end
    complete_run();
  end
endmodule // icf_fifo_ctrl_tb_top

// File: test/icf_shifter_model.sv
// shifter model on the link clock: takes tx bytes, offers rx bytes
`timescale 1ns/1ps
module icf_shifter_model
  import icf_pkg::*;
(
  // link
  input wire logic clk_link,
  input wire logic rst_b,
  input wire logic [7:0] link_tx_data,
  input wire logic link_tx_valid,
  output logic link_tx_ready,
  output icf_byte_t link_rx,
  input wire logic link_rx_ready,
  // bench control
  input wire logic stall,
  input wire logic rx_en,
  output logic [7:0] n_taken,
  output logic [7:0] last_tx,
  output logic [7:0] prev_tx
);
  logic [7:0] rx_n;
  assign link_tx_ready = ~stall;
  // released data line shows the inverse, not the last byte
  assign link_rx = '{data: (rx_en ? 8'ha0 + rx_n : ~(8'ha0 + rx_n)), valid: rx_en};
  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      n_taken <= 8'h00;
      last_tx <= 8'h00;
      prev_tx <= 8'h00;
      rx_n <= 8'h00;
    end else begin
      if (link_tx_valid && link_tx_ready) begin
        n_taken <= n_taken + 8'h01;
        last_tx <= link_tx_data;
        prev_tx <= last_tx;
      end
      if (link_rx.valid && link_rx_ready) begin
        rx_n <= rx_n + 8'h01;
      end
    end
  end
endmodule // icf_shifter_model
